/* File: design/bit_sync2.sv */
`timescale 1ns/1ps

module bit_sync2 (
	input  wire logic clk,
	input  wire logic d,
	output logic      q
);

	logic meta_q;
	logic sync_q;

	always_ff @(posedge clk) begin
		meta_q <= d;
		sync_q <= meta_q;
	end

	assign q = sync_q;

endmodule

/* File: design/serial_port_config_regs.sv */
`timescale 1ns/1ps
`include "spcfg_defs.svh"

module serial_port_config_regs (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        link_sclk,
	input  wire logic        cs_n,
	input  wire logic        sdio_in,
	output logic             sdio_out,
	output logic             sdio_oe_n,
	output logic             sdo_out,
	output logic             sdo_oe_n,
	input  wire logic        profile_load_en,
	input  wire logic        pin_prog_en,
	input  wire logic [12:0] nvm_rd_addr,
	output logic      [7:0]  nvm_rd_data,
	output logic             nvm_rd_keep,
	output logic             four_wire_en,
	output logic             lsb_first,
	output logic             auto_update_dis,
	output logic             two_wire_spi,
	output logic             multifunction_pin_five_free,
	output logic             read_buffered,
	output logic             update_strobe,
	output logic             soft_reset_pulse,
	output logic             nvm_download_req,
	output logic             core_reset_pulse,
	output logic      [15:0] scratch_active
);

	function automatic logic [7:0] reg_byte(input logic [12:0] a, input logic [7:0] cfg,
		input logic [7:0] rbc, input logic [15:0] scr);
		logic [7:0] r;
		r = `BYTE_ZERO;
		unique case (a)
			`ADDR_SERIAL_CFG:   r = cfg;
			`ADDR_READBACK_CTL: r = rbc;
			`ADDR_SOFT_UPDATE:  r = `BYTE_ZERO;
			`ADDR_FAMILY_ID_LO: r = `FAMILY_ID_LO;
			`ADDR_FAMILY_ID_HI: r = `FAMILY_ID_HI;
			`ADDR_SCRATCH_LO:   r = scr[7:0];
			`ADDR_SCRATCH_HI:   r = scr[15:8];
			default:            r = `BYTE_ZERO;
		endcase
		return r;
	endfunction

	// system clock domain
	logic [7:0]       cfg_q, cfg_d;
	logic [7:0]       rbc_q, rbc_d;
	logic [15:0]      scr_buf_q, scr_buf_d;
	logic [15:0]      scr_act_q, scr_act_d;
	logic             soft_q, soft_d;
	logic             core_q, core_d;
	logic             upd_q, upd_d;
	logic             dl_q, dl_d;
	logic [7:0]       nvm_data_q, nvm_data_d;
	logic             nvm_keep_q, nvm_keep_d;
	logic [`IMG_W-1:0] img_sent_q, img_sent_d;
	logic [`IMG_W-1:0] img_view;
	logic             img_send;
	logic             img_busy;
	logic [`WR_W-1:0] wr_pkt;
	logic             wr_valid;
	logic [12:0]      wr_addr;
	logic [7:0]       wr_data;

	assign wr_addr = wr_pkt[`WR_ADDR_RANGE];
	assign wr_data = wr_pkt[`WR_DATA_RANGE];

	always_comb begin
		cfg_d      = cfg_q;
		rbc_d      = rbc_q;
		scr_buf_d  = scr_buf_q;
		scr_act_d  = scr_act_q;
		soft_d     = 1'b0;
		core_d     = 1'b0;
		upd_d      = 1'b0;
		dl_d       = 1'b0;
		if (upd_q) begin
			scr_act_d = scr_buf_q;
		end
		if (wr_valid) begin
			unique case (wr_addr)
				`ADDR_SERIAL_CFG: begin
					cfg_d  = wr_data & `CFG_STORE_MASK;
					soft_d = wr_data[`CFG_SOFT_RESET_BIT];
					dl_d   = wr_data[`CFG_SOFT_RESET_BIT] & (profile_load_en | pin_prog_en);
				end
				`ADDR_READBACK_CTL: begin
					rbc_d  = wr_data & `RBC_STORE_MASK;
					core_d = wr_data[`RBC_CORE_RESET_BIT];
				end
				`ADDR_SOFT_UPDATE: begin
					upd_d = wr_data[`UPD_STROBE_BIT];
				end
				`ADDR_SCRATCH_LO: begin
					scr_buf_d[7:0] = wr_data;
				end
				`ADDR_SCRATCH_HI: begin
					scr_buf_d[15:8] = wr_data;
				end
				default: begin
				end
			endcase
		end
		// a soft reset clears the map one cycle after its pulse
		if (!resetn || soft_q) begin
			cfg_d     = `CFG_RESET;
			rbc_d     = `RBC_RESET;
			scr_buf_d = `SCRATCH_RESET;
			scr_act_d = `SCRATCH_RESET;
			core_d    = 1'b0;
			upd_d     = 1'b0;
		end
		if (!resetn) begin
			soft_d = 1'b0;
			dl_d   = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		cfg_q     <= cfg_d;
		rbc_q     <= rbc_d;
		scr_buf_q <= scr_buf_d;
		scr_act_q <= scr_act_d;
		soft_q    <= soft_d;
		core_q    <= core_d;
		upd_q     <= upd_d;
		dl_q      <= dl_d;
	end

	// image of readable state for the link side; the scratch view follows readback select
	always_comb begin
		img_view = {cfg_q, rbc_q,
			rbc_q[`RBC_READ_BUF_BIT] ? scr_buf_q : scr_act_q};
		img_send = (img_view != img_sent_q) && !img_busy;
		img_sent_d = img_send ? img_view : img_sent_q;
		nvm_data_d = reg_byte(nvm_rd_addr, cfg_q, rbc_q, scr_act_q);
		nvm_keep_d = (nvm_rd_addr != `ADDR_SERIAL_CFG);
		if (!resetn) begin
			img_sent_d = `IMG_RESET;
			nvm_data_d = `BYTE_ZERO;
			nvm_keep_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		img_sent_q <= img_sent_d;
		nvm_data_q <= nvm_data_d;
		nvm_keep_q <= nvm_keep_d;
	end

	assign four_wire_en                = cfg_q[`CFG_FOUR_WIRE_BIT];
	assign lsb_first                   = cfg_q[`CFG_LSB_FIRST_BIT];
	assign auto_update_dis             = rbc_q[`RBC_AUTO_DIS_BIT];
	assign two_wire_spi                = rbc_q[`RBC_TWO_WIRE_BIT];
	assign multifunction_pin_five_free = rbc_q[`RBC_TWO_WIRE_BIT];
	assign read_buffered               = rbc_q[`RBC_READ_BUF_BIT];
	assign update_strobe               = upd_q;
	assign soft_reset_pulse            = soft_q;
	assign nvm_download_req            = dl_q;
	assign core_reset_pulse            = core_q;
	assign scratch_active              = scr_act_q;
	assign nvm_rd_data                 = nvm_data_q;
	assign nvm_rd_keep                 = nvm_keep_q;

	// link clock domain
	logic              link_rstn;
	logic [`IMG_W-1:0] img_l;
	logic              lk_lsb;
	logic              lk_four;
	logic              lk_two;
	logic              frame_clr;
	spcfg_pkg::link_state_t st_q, st_d;
	logic [3:0]        cnt_q, cnt_d;
	logic [15:0]       sh_q, sh_d;
	logic [12:0]       addr_q, addr_d;
	logic [12:0]       addr_nx;
	logic [1:0]        left_q, left_d;
	logic [7:0]        tx_q, tx_d;
	logic [7:0]        rx_byte;
	logic              wr_send;
	logic [`WR_W-1:0]  wr_word;
	logic              wr_busy;
	logic              out_q, out_d;
	logic              sdio_oe_n_q, sdio_oe_n_d;
	logic              sdo_oe_n_q, sdo_oe_n_d;

	bit_sync2 u_link_rst (.clk(link_sclk), .d(resetn), .q(link_rstn));

	word_handshake_cdc #(.WIDTH(`IMG_W)) u_img_cdc (
		.src_clk    (sys_clk),
		.src_resetn (resetn),
		.src_send   (img_send),
		.src_data   (img_view),
		.src_busy   (img_busy),
		.dst_clk    (link_sclk),
		.dst_resetn (link_rstn),
		.dst_data   (img_l),
		.dst_valid  ()
	);

	word_handshake_cdc #(.WIDTH(`WR_W)) u_wr_cdc (
		.src_clk    (link_sclk),
		.src_resetn (link_rstn),
		.src_send   (wr_send),
		.src_data   (wr_word),
		.src_busy   (wr_busy),
		.dst_clk    (sys_clk),
		.dst_resetn (resetn),
		.dst_data   (wr_pkt),
		.dst_valid  (wr_valid)
	);

	assign lk_lsb  = img_l[`IMG_CFG_BASE + `CFG_LSB_FIRST_BIT];
	assign lk_four = img_l[`IMG_CFG_BASE + `CFG_FOUR_WIRE_BIT];
	assign lk_two  = img_l[`IMG_RBC_BASE + `RBC_TWO_WIRE_BIT];
	// in two-wire mode only bit counting frames a transfer, so chip select is ignored
	assign frame_clr = cs_n & ~lk_two;

	always_comb begin
		sh_d    = lk_lsb ? {sdio_in, sh_q[15:1]} : {sh_q[14:0], sdio_in};
		rx_byte = lk_lsb ? sh_d[15:8] : sh_d[7:0];
		addr_nx = lk_lsb ? addr_q + `ADDR_ONE : addr_q - `ADDR_ONE;
		st_d    = st_q;
		cnt_d   = cnt_q + `CNT_ONE;
		addr_d  = addr_q;
		left_d  = left_q;
		tx_d    = tx_q;
		wr_send = 1'b0;
		wr_word = {addr_q, rx_byte};
		unique case (st_q)
			spcfg_pkg::ST_INSTR: begin
				if (cnt_q == `CNT_LAST_INSTR) begin
					cnt_d  = `CNT_ZERO;
					addr_d = sh_d[`INSTR_ADDR_RANGE];
					left_d = sh_d[`INSTR_LEN_RANGE];
					tx_d   = reg_byte(sh_d[`INSTR_ADDR_RANGE], img_l[`IMG_CFG_RANGE],
						img_l[`IMG_RBC_RANGE], img_l[`IMG_SCR_RANGE]);
					st_d   = sh_d[`INSTR_RD_BIT] ? spcfg_pkg::ST_RDATA : spcfg_pkg::ST_WDATA;
				end
			end
			spcfg_pkg::ST_WDATA, spcfg_pkg::ST_RDATA: begin
				if (cnt_q == `CNT_LAST_BYTE) begin
					cnt_d   = `CNT_ZERO;
					wr_send = (st_q == spcfg_pkg::ST_WDATA);
					addr_d  = addr_nx;
					tx_d    = reg_byte(addr_nx, img_l[`IMG_CFG_RANGE],
						img_l[`IMG_RBC_RANGE], img_l[`IMG_SCR_RANGE]);
					// the count is exact; a streaming transfer only ends with chip select
					if (left_q == `LEN_LAST) begin
						st_d = spcfg_pkg::ST_INSTR;
					end else if (left_q != `LEN_STREAM) begin
						left_d = left_q - 2'h1;
					end
				end
			end
		endcase
		if (!link_rstn) begin
			st_d    = spcfg_pkg::ST_INSTR;
			cnt_d   = `CNT_ZERO;
			addr_d  = `ADDR_ZERO;
			left_d  = `LEN_LAST;
			tx_d    = `BYTE_ZERO;
			wr_send = 1'b0;
		end
	end

	always_ff @(posedge link_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			st_q   <= spcfg_pkg::ST_INSTR;
			cnt_q  <= `CNT_ZERO;
			sh_q   <= 16'h0000;
			addr_q <= `ADDR_ZERO;
			left_q <= `LEN_LAST;
			tx_q   <= `BYTE_ZERO;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sh_q   <= sh_d;
			addr_q <= addr_d;
			left_q <= left_d;
			tx_q   <= tx_d;
		end
	end

	// read data changes on the falling edge so the host samples it on the rising one
	always_comb begin
		out_d = lk_lsb ? tx_q[cnt_q[2:0]] : tx_q[`BIT_TOP - cnt_q[2:0]];
		sdio_oe_n_d = !((st_q == spcfg_pkg::ST_RDATA) && !lk_four);
		sdo_oe_n_d  = !((st_q == spcfg_pkg::ST_RDATA) && lk_four);
	end

	always_ff @(negedge link_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			out_q       <= 1'b0;
			sdio_oe_n_q <= 1'b1;
			sdo_oe_n_q  <= 1'b1;
		end else begin
			out_q       <= out_d;
			sdio_oe_n_q <= sdio_oe_n_d;
			sdo_oe_n_q  <= sdo_oe_n_d;
		end
	end

	assign sdio_out  = out_q;
	assign sdo_out   = out_q;
	assign sdio_oe_n = sdio_oe_n_q;
	assign sdo_oe_n  = sdo_oe_n_q;

endmodule

/* File: design/spcfg_defs.svh */
`ifndef SPCFG_DEFS_SVH
`define SPCFG_DEFS_SVH

// register addresses on the serial port
`define ADDR_SERIAL_CFG     13'h0000
`define ADDR_READBACK_CTL   13'h0004
`define ADDR_SOFT_UPDATE    13'h0005
`define ADDR_FAMILY_ID_LO   13'h000c
`define ADDR_FAMILY_ID_HI   13'h000d
`define ADDR_SCRATCH_LO     13'h000e
`define ADDR_SCRATCH_HI     13'h000f

// field positions
`define CFG_FOUR_WIRE_BIT   7
`define CFG_LSB_FIRST_BIT   6
`define CFG_SOFT_RESET_BIT  5
`define RBC_CORE_RESET_BIT  4
`define RBC_AUTO_DIS_BIT    3
`define RBC_TWO_WIRE_BIT    1
`define RBC_READ_BUF_BIT    0
`define UPD_STROBE_BIT      0

// bits that hold state; everything else reads as zero
`define CFG_STORE_MASK      8'hc0
`define RBC_STORE_MASK      8'h0b

// reset values
`define CFG_RESET           8'h00
`define RBC_RESET           8'h00
`define SCRATCH_RESET       16'h0000
`define BYTE_ZERO           8'h00

// family identifier; the value is arbitrary
`define FAMILY_ID_LO        8'h3c
`define FAMILY_ID_HI        8'h5a

// instruction word: read flag, byte count code, 13-bit address
`define INSTR_RD_BIT        15
`define INSTR_LEN_RANGE     14:13
`define INSTR_ADDR_RANGE    12:0
`define LEN_STREAM          2'h3
`define LEN_LAST            2'h0
`define CNT_LAST_INSTR      4'hf
`define CNT_LAST_BYTE       4'h7
`define CNT_ZERO            4'h0
`define CNT_ONE             4'h1
`define BIT_TOP             3'h7
`define ADDR_ONE            13'h0001
`define ADDR_ZERO           13'h0000

// register image sent to the link domain
`define IMG_W               32
`define IMG_CFG_RANGE       31:24
`define IMG_RBC_RANGE       23:16
`define IMG_SCR_RANGE       15:0
`define IMG_CFG_BASE        24
`define IMG_RBC_BASE        16
`define IMG_RESET           32'h0000_0000

// write packet sent to the system domain
`define WR_W                21
`define WR_ADDR_RANGE       20:8
`define WR_DATA_RANGE       7:0
`define WR_RESET            21'h00_0000

`endif

/* File: design/spcfg_pkg.sv */
package spcfg_pkg;

	typedef enum logic [1:0] {
		ST_INSTR,
		ST_WDATA,
		ST_RDATA
	} link_state_t;

endpackage

/* File: design/word_handshake_cdc.sv */
`timescale 1ns/1ps

// toggle handshake for a word; source data is held until the far side acks
module word_handshake_cdc #(
	parameter int WIDTH = 8
) (
	input  wire logic             src_clk,
	input  wire logic             src_resetn,
	input  wire logic             src_send,
	input  wire logic [WIDTH-1:0] src_data,
	output logic                  src_busy,
	input  wire logic             dst_clk,
	input  wire logic             dst_resetn,
	output logic [WIDTH-1:0]      dst_data,
	output logic                  dst_valid
);

	logic             req_q, req_d;
	logic [WIDTH-1:0] hold_q, hold_d;
	logic             ack_s;
	logic             req_s;
	logic             seen_q, seen_d;
	logic [WIDTH-1:0] data_q, data_d;
	logic             valid_q, valid_d;

	bit_sync2 u_ack_sync (.clk(src_clk), .d(seen_q), .q(ack_s));
	bit_sync2 u_req_sync (.clk(dst_clk), .d(req_q), .q(req_s));

	assign src_busy = req_q ^ ack_s;

	always_comb begin
		req_d  = req_q;
		hold_d = hold_q;
		if (src_send && !src_busy) begin
			req_d  = ~req_q;
			hold_d = src_data;
		end
		if (!src_resetn) begin
			req_d  = 1'b0;
			hold_d = '0;
		end
	end

	always_ff @(posedge src_clk) begin
		req_q  <= req_d;
		hold_q <= hold_d;
	end

	always_comb begin
		seen_d  = seen_q;
		data_d  = data_q;
		valid_d = 1'b0;
		// hold_q is stable while the toggle is in flight, so sampling it here is safe
		if (req_s != seen_q) begin
			seen_d  = req_s;
			data_d  = hold_q;
			valid_d = 1'b1;
		end
		if (!dst_resetn) begin
			seen_d  = 1'b0;
			data_d  = '0;
			valid_d = 1'b0;
		end
	end

	always_ff @(posedge dst_clk) begin
		seen_q  <= seen_d;
		data_q  <= data_d;
		valid_q <= valid_d;
	end

	assign dst_data  = data_q;
	assign dst_valid = valid_q;

endmodule

/* File: verification/serial_port_config_regs_assertions.sv */
`timescale 1ns/1ps

module spcfg_checker (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        cs_n,
	input wire logic        sdio_oe_n,
	input wire logic        sdo_oe_n,
	input wire logic [12:0] nvm_rd_addr,
	input wire logic        nvm_rd_keep,
	input wire logic        four_wire_en,
	input wire logic        lsb_first,
	input wire logic        two_wire_spi,
	input wire logic        multifunction_pin_five_free,
	input wire logic        update_strobe,
	input wire logic        soft_reset_pulse,
	input wire logic        nvm_download_req,
	input wire logic        core_reset_pulse,
	input wire logic [15:0] scratch_active
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence map_cleared;
		!four_wire_en && !lsb_first && !two_wire_spi && scratch_active == 16'h0000;
	endsequence
	sequence one_wide(sig);
		sig ##1 !sig;
	endsequence

	chk_soft_clears: assert property (soft_reset_pulse |-> ##[1:3] map_cleared)
		else $error("map not cleared after soft reset");
	chk_soft_single: assert property (soft_reset_pulse |-> one_wide(soft_reset_pulse))
		else $error("soft reset pulse too long");
	chk_dl_with_reset: assert property (nvm_download_req |-> soft_reset_pulse)
		else $error("download without soft reset");
	chk_update_single: assert property (update_strobe |-> one_wide(update_strobe))
		else $error("update strobe does not clear");
	chk_scratch_cause: assert property (!$stable(scratch_active) |->
		$past(update_strobe) || $past(soft_reset_pulse) || $past(soft_reset_pulse, 2))
		else $error("scratch changed without update");
	chk_keep_addr: assert property (1'h1 |=>
		nvm_rd_keep == ($past(nvm_rd_addr) != 13'h0000))
		else $error("save flag wrong for address");
	chk_core_keeps: assert property (core_reset_pulse |=>
		($stable(scratch_active) && $stable(lsb_first)) [*3])
		else $error("core reset lost register values");
	chk_pin_five: assert property (multifunction_pin_five_free == two_wire_spi)
		else $error("pin five freedom differs from mode");
	chk_sdo_four: assert property (!sdo_oe_n |-> four_wire_en)
		else $error("sdo driven in 3-wire mode");
	chk_sdio_three: assert property (!sdio_oe_n |-> !four_wire_en)
		else $error("shared line driven in 4-wire mode");
	chk_oe_framed: assert property (cs_n && $past(cs_n) && !two_wire_spi |->
		sdio_oe_n && sdo_oe_n)
		else $error("output driven with chip select high");
endmodule

bind serial_port_config_regs spcfg_checker spcfg_checker_i (
	.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .sdio_oe_n(sdio_oe_n),
	.sdo_oe_n(sdo_oe_n), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_keep(nvm_rd_keep),
	.four_wire_en(four_wire_en), .lsb_first(lsb_first), .two_wire_spi(two_wire_spi),
	.multifunction_pin_five_free(multifunction_pin_five_free),
	.update_strobe(update_strobe), .soft_reset_pulse(soft_reset_pulse),
	.nvm_download_req(nvm_download_req), .core_reset_pulse(core_reset_pulse),
	.scratch_active(scratch_active)
);

/* File: verification/serial_port_config_regs_tb.sv */
`timescale 1ns/1ps
`include "spcfg_defs.svh"

module serial_port_config_regs_tb;
	logic        sys_clk         = 1'h0;
	logic        resetn          = 1'h0;
	logic        profile_load_en = 1'h0;
	logic        pin_prog_en     = 1'h0;
	logic [12:0] nvm_rd_addr     = 13'h0000;
	logic        lsb_m           = 1'h0;
	logic        cs_m            = 1'h1;
	logic [23:0] rv;
	wire         link_sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, sdo_out, sdo_oe_n;
	wire         nvm_rd_keep, four_wire_en, lsb_first, auto_update_dis, two_wire_spi;
	wire         mpf_free, read_buffered, update_strobe, soft_reset_pulse;
	wire         nvm_download_req, core_reset_pulse;
	wire  [7:0]  nvm_rd_data;
	wire  [15:0] scratch_active;
	int          failures        = 0;
	int          checks_done     = 0;
	int          upd_cnt         = 0;
	int          srst_cnt        = 0;
	int          dl_cnt          = 0;
	int          core_cnt        = 0;
	logic [12:0] addr_tab [7]    = '{13'h0000, 13'h0004, 13'h0005, 13'h000c, 13'h000d,
		13'h000e, 13'h000f};
	logic [7:0]  rst_tab [7]     = '{8'h00, 8'h00, 8'h00, `FAMILY_ID_LO, `FAMILY_ID_HI,
		8'h00, 8'h00};

	always #4 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		upd_cnt  <= upd_cnt + int'(update_strobe);
		srst_cnt <= srst_cnt + int'(soft_reset_pulse);
		dl_cnt   <= dl_cnt + int'(nvm_download_req);
		core_cnt <= core_cnt + int'(core_reset_pulse);
	end

	serial_port_config_regs serial_port_config_regs_i (
		.sys_clk(sys_clk), .resetn(resetn), .link_sclk(link_sclk), .cs_n(cs_n),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out),
		.sdo_oe_n(sdo_oe_n), .profile_load_en(profile_load_en), .pin_prog_en(pin_prog_en),
		.nvm_rd_addr(nvm_rd_addr), .nvm_rd_data(nvm_rd_data), .nvm_rd_keep(nvm_rd_keep),
		.four_wire_en(four_wire_en), .lsb_first(lsb_first), .auto_update_dis(auto_update_dis),
		.two_wire_spi(two_wire_spi), .multifunction_pin_five_free(mpf_free),
		.read_buffered(read_buffered), .update_strobe(update_strobe),
		.soft_reset_pulse(soft_reset_pulse), .nvm_download_req(nvm_download_req),
		.core_reset_pulse(core_reset_pulse), .scratch_active(scratch_active)
	);

	spi_host_model spi_host_model_i (
		.link_sclk(link_sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
		.sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n)
	);

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [12:0] a, input int n, input logic [23:0] d);
		spi_host_model_i.xfer(1'h0, a, n, lsb_m, cs_m, d, rv);
	endtask

	task automatic rd(input logic [12:0] a, input int n);
		spi_host_model_i.xfer(1'h1, a, n, lsb_m, cs_m, 24'h000000, rv);
	endtask

	task automatic t_defaults;
		for (int i = 0; i < 7; i++) begin
			rd(addr_tab[i], 1);
			check(rv, {16'h0000, rst_tab[i]});
		end
		check(24'({four_wire_en, lsb_first, two_wire_spi, read_buffered}), 24'h0);
		$display("test defaults done");
	endtask

	task automatic t_buffer;
		int n;
		wr(13'h000f, 2, 24'h003412);
		rd(13'h000f, 2);
		check(rv, 24'h000000);
		wr(13'h0004, 1, 24'h000001);
		rd(13'h000f, 2);
		check(rv, 24'h003412);
		check(24'(read_buffered), 24'h000001);
		n = upd_cnt;
		wr(13'h0005, 1, 24'h0000ff);
		check(24'(upd_cnt - n), 24'h000001);
		check(24'(scratch_active), 24'h001234);
		rd(13'h0005, 1);
		check(rv, 24'h000000);
		$display("test buffer done");
	endtask

	task automatic t_reserved;
		wr(13'h000d, 2, 24'h00ffff);
		wr(13'h0000, 1, 24'h00001f);
		wr(13'h0004, 1, 24'h0000e4);
		wr(13'h0020, 1, 24'h0000ff);
		rd(13'h000d, 2);
		check(rv, {8'h00, `FAMILY_ID_LO, `FAMILY_ID_HI});
		for (int i = 0; i < 3; i++) begin
			rd(i == 2 ? 13'h0020 : addr_tab[i], 1);
			check(rv, 24'h000000);
		end
		rd(13'h000f, 3);
		check(rv, {`FAMILY_ID_HI, 8'h34, 8'h12});
		$display("test reserved done");
	endtask

	task automatic t_core;
		int n;
		n = core_cnt;
		wr(13'h0004, 1, 24'h000018);
		check(24'(core_cnt - n), 24'h000001);
		check(24'(scratch_active), 24'h001234);
		check(24'(auto_update_dis), 24'h000001);
		rd(13'h0004, 1);
		check(rv, 24'h000008);
		$display("test core reset done");
	endtask

	task automatic t_lsb;
		wr(13'h0000, 1, 24'h000040);
		spi_host_model_i.idle(8);
		lsb_m = 1'h1;
		check(24'(lsb_first), 24'h000001);
		wr(13'h0004, 1, 24'h000001);
		wr(13'h000e, 2, 24'h00cdab);
		rd(13'h000e, 2);
		check(rv, 24'h00cdab);
		wr(13'h0005, 1, 24'h000001);
		check(24'(scratch_active), 24'h00cdab);
		wr(13'h0000, 1, 24'h000000);
		spi_host_model_i.idle(8);
		lsb_m = 1'h0;
		$display("test lsb first done");
	endtask

	task automatic t_four;
		wr(13'h0000, 1, 24'h000080);
		spi_host_model_i.idle(8);
		spi_host_model_i.four_m = 1'h1;
		check(24'(four_wire_en), 24'h000001);
		rd(13'h000e, 2);
		check(rv, {8'h00, `FAMILY_ID_HI, 8'hab});
		wr(13'h0000, 1, 24'h000000);
		spi_host_model_i.idle(8);
		spi_host_model_i.four_m = 1'h0;
		$display("test four wire done");
	endtask

	task automatic t_two;
		wr(13'h0004, 1, 24'h000002);
		rd(13'h000c, 1);
		check(24'({two_wire_spi, mpf_free}), 24'h000003);
		cs_m = 1'h0;
		rd(13'h0004, 1);
		check(rv, 24'h000002);
		wr(13'h0004, 1, 24'h000000);
		cs_m = 1'h1;
		rd(13'h000c, 1);
		check(rv, 24'(`FAMILY_ID_LO));
		check(24'({two_wire_spi, mpf_free}), 24'h000000);
		$display("test two wire done");
	endtask

	task automatic t_soft;
		int         n;
		int         m;
		logic [7:0] e;
		for (int i = 0; i < 7; i++) begin
			@(posedge sys_clk) #1 nvm_rd_addr = addr_tab[i];
			repeat (2) @(posedge sys_clk);
			e = i == 5 ? 8'hab : (i == 6 ? 8'hcd : rst_tab[i]);
			#1 check({16'h0000, nvm_rd_data}, {16'h0000, e});
			check(24'(nvm_rd_keep), 24'(i != 0));
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk) #1 pin_prog_en = i[1];
			profile_load_en = i[0];
			n = srst_cnt;
			m = dl_cnt;
			wr(13'h0000, 1, 24'h000020);
			check(24'(srst_cnt - n), 24'h000001);
			check(24'(dl_cnt - m), 24'(i != 0));
		end
		check(24'(scratch_active), 24'h000000);
		rd(13'h000e, 1);
		check(rv, 24'h000000);
		$display("test soft reset done");
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#300000;
		failures++;
		test_done();
	end

	initial begin
		// the link side synchronises reset, so it needs edges while reset is low
		spi_host_model_i.idle(4);
		@(posedge sys_clk) #1 resetn = 1'h1;
		// keep the link edges away from the rising system clock edges; they land on its falling edges
		#3 spi_host_model_i.idle(4);
		t_defaults();
		t_buffer();
		t_reserved();
		t_core();
		t_lsb();
		t_four();
		t_two();
		t_soft();
		test_done();
	end
endmodule

/* File: verification/spi_host_model.sv */
`timescale 1ns/1ps

module spi_host_model (
	output logic      link_sclk,
	output logic      cs_n,
	output logic      sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe_n,
	input  wire logic sdo_out,
	input  wire logic sdo_oe_n
);
	logic host_bit = 1'h0;
	logic host_drv = 1'h0;
	logic four_m   = 1'h0;

	initial begin
		link_sclk = 1'h0;
		cs_n = 1'h1;
	end
	// a released line shows the inverse of the last bit, never a stale copy
	assign sdio_in = !sdio_oe_n ? sdio_out : (host_drv ? host_bit : ~host_bit);

	task automatic shift(input logic b, output logic s);
		host_bit = b;
		#16;
		s = four_m ? (sdo_oe_n ? ~host_bit : sdo_out) : sdio_in;
		link_sclk = 1'h1;
		#16 link_sclk = 1'h0;
	endtask

	// edges with chip select high let the register image cross
	task automatic idle(input int n);
		repeat (n) begin
			#16 link_sclk = 1'h1;
			#16 link_sclk = 1'h0;
		end
	endtask

	task automatic xfer(input logic rd, input logic [12:0] a, input int n, input logic lsb,
			input logic use_cs, input logic [23:0] wd, output logic [23:0] q);
		logic [15:0] ins;
		logic        s;
		int          k;
		ins = {rd, 2'(n - 1), a};
		q = 24'h000000;
		cs_n = !use_cs;
		host_drv = 1'h1;
		#16;
		for (int i = 0; i < 16; i++) begin
			shift(ins[lsb ? i : 15 - i], s);
		end
		host_drv = !rd;
		for (int i = 0; i < 8 * n; i++) begin
			k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
			shift(wd[k], s);
			q[k] = s;
		end
		host_drv = 1'h0;
		#16 cs_n = 1'h1;
		#32;
	endtask
endmodule
